// ==== logic/analog_route_and_startup_ctrl.sv ====
`timescale 1ns/1ps
module analog_route_and_startup_ctrl
	import arsc_pkg::*;
#(
	parameter int SAMPLE_W = 16,
	parameter int ACT_WIN = 64,
	parameter int BIT_HALF = 4,
	parameter int FRAME_BITS = 32
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic power_down_reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata,
	input wire logic master_sel,
	input wire logic ref_voltage_power,
	input wire logic [1:0] audio_format_sel,
	input wire logic [1:0] sample_rate_sel,
	input wire logic master_clock_in,
	input wire logic frame_clock_in,
	output logic frame_clock_out,
	output logic frame_clock_oe,
	input wire logic bit_clock_in,
	output logic bit_clock_out,
	output logic bit_clock_oe,
	output logic normal_op,
	output logic device_in_reset,
	output logic [3:0] startup_state,
	output logic [2:0] clocks_present,
	output logic [3:0] active_format,
	output logic line_out_diff_sel,
	output logic line_out_stereo_en,
	output logic mix_source_stereo_sel,
	output logic mono_input_sel,
	output logic input4_diff_sel,
	output logic micamp_left_route,
	output logic micamp_right_route,
	output logic [5:0] lo_in_sw,
	output logic lo_mic_mono_mix,
	output logic lo_dac_mono_mix,
	output logic [5:0] hp_in_sw,
	output logic hp_mic_mono_mix,
	input wire logic adc_valid,
	input wire logic [SAMPLE_W-1:0] adc_left,
	input wire logic [SAMPLE_W-1:0] adc_right,
	output logic rec_valid,
	output logic [SAMPLE_W-1:0] rec_left,
	output logic [SAMPLE_W-1:0] rec_right,
	input wire logic dac_valid,
	input wire logic [SAMPLE_W-1:0] dac_left,
	input wire logic [SAMPLE_W-1:0] dac_right,
	output logic lo_dac_valid,
	output logic [SAMPLE_W-1:0] lo_dac_left,
	output logic [SAMPLE_W-1:0] lo_dac_right,
	output logic [SAMPLE_W-1:0] dac_code_left,
	output logic [SAMPLE_W-1:0] dac_code_right
);
	arsc_route_if route ();
	arsc_state_e state;

	arsc_regs u_regs (
		.ref_clk(ref_clk),
		.rst(rst),
		.route(route.bank),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_we(reg_we),
		.reg_re(reg_re),
		.reg_rdata(reg_rdata)
	);

	arsc_startup #(
		.ACT_WIN(ACT_WIN),
		.BIT_HALF(BIT_HALF),
		.FRAME_BITS(FRAME_BITS)
	) u_startup (
		.ref_clk(ref_clk),
		.rst(rst),
		.route(route.seq),
		.power_down_reset_n(power_down_reset_n),
		.master_sel(master_sel),
		.ref_voltage_power(ref_voltage_power),
		.master_clock_in(master_clock_in),
		.frame_clock_in(frame_clock_in),
		.bit_clock_in(bit_clock_in),
		.frame_clock_out(frame_clock_out),
		.frame_clock_oe(frame_clock_oe),
		.bit_clock_out(bit_clock_out),
		.bit_clock_oe(bit_clock_oe),
		.clocks_present(clocks_present),
		.state(state)
	);

	assign normal_op = route.normal_op;
	assign device_in_reset = route.dev_reset;
	assign startup_state = state;

	// Format and rate follow the selects in the configuration state and freeze once the reference powers up, so later edits wait for a restart.
	logic [3:0] fmt_ff;
	wire fmt_load = state == ARSC_ST_CONFIG;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) fmt_ff <= 4'h0;
		else if (fmt_load) fmt_ff <= {sample_rate_sel, audio_format_sel};
	end
	assign active_format = fmt_ff;

	// Source-mode register decode.
	wire [7:0] src = route.src_mode;
	assign line_out_diff_sel = src[ARSC_SRC_LO_DIFF];
	assign line_out_stereo_en = ~src[ARSC_SRC_LO_DIFF];
	assign mix_source_stereo_sel = src[ARSC_SRC_MIX_STEREO];
	assign mono_input_sel = ~src[ARSC_SRC_MIX_STEREO];
	assign input4_diff_sel = src[ARSC_SRC_IN4_DIFF];
	assign micamp_left_route = src[ARSC_SRC_MIC_LEFT];
	assign micamp_right_route = src[ARSC_SRC_MIC_RIGHT];
	wire mono_rec = src[ARSC_SRC_MONO_REC];

	// Mix register decode.
	// line-out input switches
	assign lo_in_sw = route.lo_mix[ARSC_MIX_SW_MSB:ARSC_MIX_SW_LSB];
	assign lo_mic_mono_mix = route.lo_mix[ARSC_MIX_MIC_MONO];
	wire lo_dac_mono = route.lo_mix[ARSC_MIX_DAC_MONO];
	assign lo_dac_mono_mix = lo_dac_mono;
	assign hp_in_sw = route.hp_mix[ARSC_MIX_SW_MSB:ARSC_MIX_SW_LSB];
	assign hp_mic_mono_mix = route.hp_mix[ARSC_MIX_MIC_MONO];

	// Averages keep one extra bit so that full-scale pairs cannot wrap.
	wire signed [SAMPLE_W:0] adc_sum = $signed({adc_left[SAMPLE_W-1], adc_left}) +
		$signed({adc_right[SAMPLE_W-1], adc_right});
	wire signed [SAMPLE_W:0] dac_sum = $signed({dac_left[SAMPLE_W-1], dac_left}) +
		$signed({dac_right[SAMPLE_W-1], dac_right});
	wire [SAMPLE_W-1:0] adc_avg = adc_sum[SAMPLE_W:1];
	wire [SAMPLE_W-1:0] dac_avg = dac_sum[SAMPLE_W:1];

	// Before the sequence reaches normal operation the DAC sees the midpoint code.
	wire [SAMPLE_W-1:0] dac_mid = SAMPLE_W'(ARSC_DAC_MID);
	wire [SAMPLE_W-1:0] adc_in [2];
	wire [SAMPLE_W-1:0] dac_in [2];
	assign adc_in[0] = adc_left;
	assign adc_in[1] = adc_right;
	assign dac_in[0] = dac_left;
	assign dac_in[1] = dac_right;

	logic [SAMPLE_W-1:0] rec_ff [2];
	logic [SAMPLE_W-1:0] lo_ff [2];
	logic [SAMPLE_W-1:0] code_ff [2];
	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_chan
			wire [SAMPLE_W-1:0] nxt_rec = mono_rec ? adc_avg : adc_in[c];
			// DAC mono mix to line out
			wire [SAMPLE_W-1:0] mixed = lo_dac_mono ? dac_avg : dac_in[c];
			wire [SAMPLE_W-1:0] nxt_lo = route.normal_op ? mixed : dac_mid;
			// two's complement to offset code, midpoint at half scale
			wire [SAMPLE_W-1:0] nxt_code = {~nxt_lo[SAMPLE_W-1], nxt_lo[SAMPLE_W-2:0]};
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					rec_ff[c] <= '0;
					lo_ff[c] <= '0;
					code_ff[c] <= {1'b1, {(SAMPLE_W-1){1'b0}}};
				end else begin
					if (adc_valid) rec_ff[c] <= nxt_rec;
					if (dac_valid) lo_ff[c] <= nxt_lo;
					if (dac_valid) code_ff[c] <= nxt_code;
				end
			end
		end
	endgenerate

	logic rec_valid_ff;
	logic lo_valid_ff;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rec_valid_ff <= 1'b0;
			lo_valid_ff <= 1'b0;
		end else begin
			rec_valid_ff <= adc_valid & route.normal_op;
			lo_valid_ff <= dac_valid;
		end
	end

	assign rec_valid = rec_valid_ff;
	assign rec_left = rec_ff[0];
	assign rec_right = rec_ff[1];
	assign lo_dac_valid = lo_valid_ff;
	assign lo_dac_left = lo_ff[0];
	assign lo_dac_right = lo_ff[1];
	assign dac_code_left = code_ff[0];
	assign dac_code_right = code_ff[1];
endmodule : analog_route_and_startup_ctrl

// ==== logic/arsc_pkg.sv ====
package arsc_pkg;

	// Register offsets of the routing bank.
	localparam logic [7:0] ARSC_ADDR_SRC_MODE = 8'h21;
	localparam logic [7:0] ARSC_ADDR_LO_MIX = 8'h22;
	localparam logic [7:0] ARSC_ADDR_HP_MIX = 8'h23;

	// Values after reset.
	localparam logic [7:0] ARSC_RST_SRC_MODE = 8'h00;
	localparam logic [7:0] ARSC_RST_LO_MIX = 8'h00;
	localparam logic [7:0] ARSC_RST_HP_MIX = 8'h00;

	// Implemented bits; everything else reads as zero.
	localparam logic [7:0] ARSC_MASK_SRC_MODE = 8'h3f;
	localparam logic [7:0] ARSC_MASK_LO_MIX = 8'hff;
	localparam logic [7:0] ARSC_MASK_HP_MIX = 8'h7f;

	// Field positions in the source-mode register.
	localparam int ARSC_SRC_LO_DIFF = 0;
	localparam int ARSC_SRC_MIX_STEREO = 1;
	localparam int ARSC_SRC_MONO_REC = 2;
	localparam int ARSC_SRC_IN4_DIFF = 3;
	localparam int ARSC_SRC_MIC_LEFT = 4;
	localparam int ARSC_SRC_MIC_RIGHT = 5;

	// Field positions in both mix registers; bit 7 (DAC mono) is implemented in the line-out mix register only.
	localparam int ARSC_MIX_SW_LSB = 0;
	localparam int ARSC_MIX_SW_MSB = 5;
	localparam int ARSC_MIX_MIC_MONO = 6;
	localparam int ARSC_MIX_DAC_MONO = 7;

	// Sample coding of the DAC input.
	localparam logic [15:0] ARSC_DAC_POS_FULL = 16'h7fff;
	localparam logic [15:0] ARSC_DAC_NEG_FULL = 16'h8000;
	localparam logic [15:0] ARSC_DAC_MID = 16'h0000;

	// Timing.
	localparam int ARSC_CLK_PERIOD_NS = 10;
	localparam int ARSC_RSTN_LOW_MIN_NS = 150;
	localparam int ARSC_RSTN_LOW_MIN_CYC = (ARSC_RSTN_LOW_MIN_NS + ARSC_CLK_PERIOD_NS - 1) / ARSC_CLK_PERIOD_NS;
	localparam logic [4:0] ARSC_RSTN_LOW_CNT_MAX = 5'(ARSC_RSTN_LOW_MIN_CYC);

	// Start-up sequence states.
	typedef enum logic [3:0] {
		ARSC_ST_RESET = 4'h1,
		ARSC_ST_CONFIG = 4'h2,
		ARSC_ST_WAIT_CLK = 4'h4,
		ARSC_ST_RUN = 4'h8
	} arsc_state_e;

endpackage : arsc_pkg

// ==== logic/arsc_regs.sv ====
`timescale 1ns/1ps
module arsc_regs
	import arsc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	arsc_route_if.bank route,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata
);
	logic [7:0] src_mode_ff;
	logic [7:0] lo_mix_ff;
	logic [7:0] hp_mix_ff;
	logic [7:0] rdata_ff;

	wire hit_src = reg_addr == ARSC_ADDR_SRC_MODE;
	wire hit_lo = reg_addr == ARSC_ADDR_LO_MIX;
	wire hit_hp = reg_addr == ARSC_ADDR_HP_MIX;
	// Writes are dropped while the device is held in power-down reset.
	wire wr_ok = reg_we & ~route.dev_reset;
	wire [7:0] nxt_src_mode = reg_wdata & ARSC_MASK_SRC_MODE;
	wire [7:0] nxt_lo_mix = reg_wdata & ARSC_MASK_LO_MIX;
	wire [7:0] nxt_hp_mix = reg_wdata & ARSC_MASK_HP_MIX;
	wire [7:0] nxt_rdata = hit_src ? src_mode_ff : hit_lo ? lo_mix_ff : hit_hp ? hp_mix_ff : 8'h00;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			src_mode_ff <= ARSC_RST_SRC_MODE;
			lo_mix_ff <= ARSC_RST_LO_MIX;
			hp_mix_ff <= ARSC_RST_HP_MIX;
		end else if (route.dev_reset) begin
			src_mode_ff <= ARSC_RST_SRC_MODE;
			lo_mix_ff <= ARSC_RST_LO_MIX;
			hp_mix_ff <= ARSC_RST_HP_MIX;
		end else if (wr_ok) begin
			if (hit_src) src_mode_ff <= nxt_src_mode;
			if (hit_lo) lo_mix_ff <= nxt_lo_mix;
			if (hit_hp) hp_mix_ff <= nxt_hp_mix;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_ff <= 8'h00;
		end else if (reg_re) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign route.src_mode = src_mode_ff;
	assign route.lo_mix = lo_mix_ff;
	assign route.hp_mix = hp_mix_ff;
	assign reg_rdata = rdata_ff;
endmodule : arsc_regs

// ==== logic/arsc_route_if.sv ====
`timescale 1ns/1ps
interface arsc_route_if;
	logic [7:0] src_mode;
	logic [7:0] lo_mix;
	logic [7:0] hp_mix;
	logic dev_reset;
	logic normal_op;

	modport bank (output src_mode, output lo_mix, output hp_mix, input dev_reset);
	modport seq (output dev_reset, output normal_op);
	modport user (input src_mode, input lo_mix, input hp_mix, input dev_reset, input normal_op);
endinterface : arsc_route_if

// ==== logic/arsc_startup.sv ====
`timescale 1ns/1ps
module arsc_startup
	import arsc_pkg::*;
#(
	parameter int ACT_WIN = 64,
	parameter int BIT_HALF = 4,
	parameter int FRAME_BITS = 32
) (
	input wire logic ref_clk,
	input wire logic rst,
	arsc_route_if.seq route,
	input wire logic power_down_reset_n,
	input wire logic master_sel,
	input wire logic ref_voltage_power,
	input wire logic master_clock_in,
	input wire logic frame_clock_in,
	input wire logic bit_clock_in,
	output logic frame_clock_out,
	output logic frame_clock_oe,
	output logic bit_clock_out,
	output logic bit_clock_oe,
	output logic [2:0] clocks_present,
	output arsc_state_e state
);
	localparam int WW = $clog2(ACT_WIN + 1);
	localparam int DW = $clog2(BIT_HALF + 1);
	localparam int FW = $clog2(FRAME_BITS + 1);

	logic [4:0] low_cnt_ff;
	logic dev_reset_ff;
	arsc_state_e state_ff;
	arsc_state_e nxt_state;
	logic [DW-1:0] div_ff;
	logic bit_ff;
	logic frame_ff;
	logic [FW-1:0] bit_cnt_ff;

	// Short low glitches on the reset pin do not reset the device.
	// The count stops one short of the minimum, so the low sample that completes it sets the reset.
	wire low_done = low_cnt_ff == ARSC_RSTN_LOW_CNT_MAX - 5'h01;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			low_cnt_ff <= 5'h00;
			dev_reset_ff <= 1'b1;
		end else if (power_down_reset_n) begin
			low_cnt_ff <= 5'h00;
			dev_reset_ff <= 1'b0;
		end else begin
			if (!low_done) low_cnt_ff <= low_cnt_ff + 5'h01;
			if (low_done) dev_reset_ff <= 1'b1;
		end
	end

	wire [2:0] clk_in = {bit_clock_in, frame_clock_in, master_clock_in};
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_act
			logic prev_ff;
			logic [WW-1:0] idle_ff;
			wire edge_seen = prev_ff != clk_in[g];
			wire expired = idle_ff == WW'(ACT_WIN);
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					prev_ff <= 1'b0;
					idle_ff <= WW'(ACT_WIN);
				end else begin
					prev_ff <= clk_in[g];
					if (edge_seen) idle_ff <= '0;
					else if (!expired) idle_ff <= idle_ff + WW'(1);
				end
			end
			assign clocks_present[g] = ~expired;
		end
	endgenerate

	wire slave_clk_ok = &clocks_present;
	wire master_clk_ok = clocks_present[0] & master_sel;
	wire clk_ok = master_sel ? master_clk_ok : slave_clk_ok;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ARSC_ST_RESET: if (!dev_reset_ff) nxt_state = ARSC_ST_CONFIG;
			ARSC_ST_CONFIG: if (ref_voltage_power) nxt_state = ARSC_ST_WAIT_CLK;
			ARSC_ST_WAIT_CLK: begin
				if (!ref_voltage_power) nxt_state = ARSC_ST_CONFIG;
				else if (clk_ok) nxt_state = ARSC_ST_RUN;
			end
			ARSC_ST_RUN: begin
				if (!ref_voltage_power) nxt_state = ARSC_ST_CONFIG;
				else if (!clk_ok) nxt_state = ARSC_ST_WAIT_CLK;
			end
			default: nxt_state = ARSC_ST_RESET;
		endcase
		if (dev_reset_ff) nxt_state = ARSC_ST_RESET;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) state_ff <= ARSC_ST_RESET;
		else state_ff <= nxt_state;
	end

	// Master clocks come from the system clock divider; they need the master clock present.
	wire gen_on = master_sel & ~dev_reset_ff & clocks_present[0];
	wire tick = div_ff == DW'(BIT_HALF - 1);
	wire bit_fall = tick & bit_ff;
	wire frame_wrap = bit_cnt_ff == FW'(FRAME_BITS / 2 - 1);
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_ff <= '0;
			bit_ff <= 1'b1;
			frame_ff <= 1'b1;
			bit_cnt_ff <= '0;
		end else if (!gen_on) begin
			div_ff <= '0;
			bit_ff <= 1'b1;
			frame_ff <= 1'b1;
			bit_cnt_ff <= '0;
		end else begin
			div_ff <= tick ? '0 : div_ff + DW'(1);
			if (tick) bit_ff <= ~bit_ff;
			if (bit_fall) bit_cnt_ff <= frame_wrap ? '0 : bit_cnt_ff + FW'(1);
			if (bit_fall && frame_wrap) frame_ff <= ~frame_ff;
		end
	end

	assign bit_clock_oe = master_sel & ~dev_reset_ff;
	assign frame_clock_oe = master_sel & ~dev_reset_ff;
	assign bit_clock_out = bit_ff;
	assign frame_clock_out = frame_ff;
	assign state = state_ff;
	assign route.dev_reset = dev_reset_ff;
	assign route.normal_op = state_ff == ARSC_ST_RUN;
endmodule : arsc_startup

// ==== sim/arsc_assertions.sv ====
`timescale 1ns/1ps
module arsc_assertions
	import arsc_pkg::*;
#(
	parameter int SAMPLE_W = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic power_down_reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [7:0] reg_rdata,
	input wire logic master_sel,
	input wire logic frame_clock_oe,
	input wire logic bit_clock_oe,
	input wire logic device_in_reset,
	input wire logic normal_op,
	input wire logic [2:0] clocks_present,
	input wire logic line_out_diff_sel,
	input wire logic line_out_stereo_en,
	input wire logic lo_dac_mono_mix,
	input wire logic dac_valid,
	input wire logic [SAMPLE_W-1:0] dac_left,
	input wire logic [SAMPLE_W-1:0] dac_code_left
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_src_wr;
		reg_we && !device_in_reset && reg_addr == ARSC_ADDR_SRC_MODE;
	endsequence
	sequence s_dac_take;
		dac_valid && normal_op && !lo_dac_mono_mix;
	endsequence

	AST_OE_FRAME: assert property (frame_clock_oe == (master_sel && !device_in_reset))
		else $error("frame clock enable wrong");
	AST_OE_BIT: assert property (!master_sel |-> !bit_clock_oe)
		else $error("bit clock driven in slave mode");
	AST_SLAVE_RUN: assert property ($rose(normal_op) && !$past(master_sel) |-> $past(clocks_present) == 3'h7)
		else $error("run entered without all clocks");
	AST_SRC_WR: assert property (s_src_wr |=> device_in_reset || line_out_diff_sel == $past(reg_wdata[0]))
		else $error("line out select not written");
	AST_DIFF_INV: assert property (line_out_stereo_en != line_out_diff_sel)
		else $error("stereo enable not inverse of diff select");
	AST_RSV_SRC: assert property (reg_re && reg_addr == ARSC_ADDR_SRC_MODE |=> reg_rdata[7:6] == 2'h0)
		else $error("reserved source bits read nonzero");
	AST_RSV_HP: assert property (reg_re && reg_addr == ARSC_ADDR_HP_MIX |=> !reg_rdata[7])
		else $error("reserved headphone bit read nonzero");
	AST_DAC_CODE: assert property (s_dac_take |=> dac_code_left[14:0] == $past(dac_left[14:0])
		&& dac_code_left[15] == !$past(dac_left[15]))
		else $error("dac code wrong");
	AST_RSTPIN_LONG: assert property ($rose(device_in_reset) |-> !$past(power_down_reset_n)
		&& !$past(power_down_reset_n, 15))
		else $error("device reset on short pulse");
	AST_RST_CLR: assert property (device_in_reset && $past(device_in_reset) |-> !line_out_diff_sel)
		else $error("routing bit set during device reset");
endmodule : arsc_assertions

// ==== sim/arsc_host_model.sv ====
`timescale 1ns/1ps
module arsc_host_model (
	input wire logic ref_clk,
	input wire logic clk_en,
	output logic master_clock_in,
	output logic frame_clock_in,
	output logic bit_clock_in
);
	logic [4:0] div_ff = 5'h0;
	always @(posedge ref_clk) begin
		if (clk_en) begin
			div_ff <= div_ff + 5'h1;
		end
	end
	// Frame toggles every 16 cycles so it stays inside the activity window.
	assign master_clock_in = div_ff[0];
	assign bit_clock_in = div_ff[1];
	assign frame_clock_in = div_ff[4];
endmodule : arsc_host_model

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	import arsc_pkg::*;
	logic ref_clk, rst, power_down_reset_n, reg_we, reg_re, master_sel, ref_voltage_power, clk_en;
	logic adc_valid, dac_valid, master_clock_in, frame_clock_in, bit_clock_in;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [1:0] audio_format_sel, sample_rate_sel;
	logic [15:0] adc_left, adc_right, dac_left, dac_right, rec_left, lo_dac_left, dac_code_left;
	logic [15:0] rec_right, lo_dac_right, dac_code_right;
	logic rec_valid, lo_dac_valid, bit_clock_out, mono_input_sel;
	logic frame_clock_oe, bit_clock_oe, normal_op, device_in_reset, line_out_diff_sel, line_out_stereo_en;
	logic mix_source_stereo_sel, input4_diff_sel, micamp_left_route, micamp_right_route;
	logic lo_mic_mono_mix, lo_dac_mono_mix, hp_mic_mono_mix;
	logic [5:0] lo_in_sw, hp_in_sw;
	logic [3:0] startup_state, active_format;
	logic [2:0] clocks_present;
	int fail_count, check_count;

	analog_route_and_startup_ctrl u_analog_route_and_startup_ctrl (.ref_clk(ref_clk), .rst(rst),
		.power_down_reset_n(power_down_reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .master_sel(master_sel),
		.ref_voltage_power(ref_voltage_power), .audio_format_sel(audio_format_sel),
		.sample_rate_sel(sample_rate_sel), .master_clock_in(master_clock_in), .frame_clock_in(frame_clock_in),
		.frame_clock_out(), .frame_clock_oe(frame_clock_oe), .bit_clock_in(bit_clock_in),
		.bit_clock_out(bit_clock_out), .bit_clock_oe(bit_clock_oe), .normal_op(normal_op),
		.device_in_reset(device_in_reset),
		.startup_state(startup_state), .clocks_present(clocks_present), .active_format(active_format),
		.line_out_diff_sel(line_out_diff_sel), .line_out_stereo_en(line_out_stereo_en),
		.mix_source_stereo_sel(mix_source_stereo_sel), .mono_input_sel(mono_input_sel),
		.input4_diff_sel(input4_diff_sel),
		.micamp_left_route(micamp_left_route), .micamp_right_route(micamp_right_route), .lo_in_sw(lo_in_sw),
		.lo_mic_mono_mix(lo_mic_mono_mix), .lo_dac_mono_mix(lo_dac_mono_mix), .hp_in_sw(hp_in_sw),
		.hp_mic_mono_mix(hp_mic_mono_mix), .adc_valid(adc_valid), .adc_left(adc_left), .adc_right(adc_right),
		.rec_valid(rec_valid), .rec_left(rec_left), .rec_right(rec_right), .dac_valid(dac_valid),
		.dac_left(dac_left), .dac_right(dac_right), .lo_dac_valid(lo_dac_valid),
		.lo_dac_left(lo_dac_left), .lo_dac_right(lo_dac_right), .dac_code_left(dac_code_left),
		.dac_code_right(dac_code_right));

	arsc_host_model u_arsc_host_model (.ref_clk(ref_clk), .clk_en(clk_en), .master_clock_in(master_clock_in),
		.frame_clock_in(frame_clock_in), .bit_clock_in(bit_clock_in));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task summarize();
		$display("checks=%0d mismatches=%0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize

	task chk(input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk

	task step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge ref_clk);
		reg_we <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge ref_clk);
		reg_re <= 1'b0;
		#1;
		chk(e, reg_rdata);
	endtask : rd

	task t_src();
		logic [7:0] v;
		for (int i = 0; i < 6; i++) begin
			v = 8'h01 << i;
			wr(ARSC_ADDR_SRC_MODE, v);
			step(1);
			chk(v & 8'h3b, {micamp_right_route, micamp_left_route, input4_diff_sel, 1'b0,
				mix_source_stereo_sel, line_out_diff_sel});
			chk(!v[1], mono_input_sel);
			rd(ARSC_ADDR_SRC_MODE, v);
		end
		wr(ARSC_ADDR_SRC_MODE, 8'hff);
		rd(ARSC_ADDR_SRC_MODE, 8'h3f);
	endtask : t_src

	task t_mix();
		wr(ARSC_ADDR_LO_MIX, 8'ha5);
		step(1);
		chk(16'h0025, lo_in_sw);
		chk(2'h2, {lo_dac_mono_mix, lo_mic_mono_mix});
		rd(ARSC_ADDR_LO_MIX, 8'ha5);
		wr(ARSC_ADDR_HP_MIX, 8'hff);
		step(1);
		chk(7'h7f, {hp_mic_mono_mix, hp_in_sw});
		rd(ARSC_ADDR_HP_MIX, 8'h7f);
		wr(ARSC_ADDR_LO_MIX, 8'h5a);
		rd(ARSC_ADDR_LO_MIX, 8'h5a);
		chk(2'h1, {lo_dac_mono_mix, lo_mic_mono_mix});
	endtask : t_mix

	task t_pin_reset();
		// A pulse under the minimum must not reset.
		@(posedge ref_clk);
		power_down_reset_n <= 1'b0;
		repeat (10) @(posedge ref_clk);
		power_down_reset_n <= 1'b1;
		step(2);
		chk(1'b0, device_in_reset);
		rd(ARSC_ADDR_LO_MIX, 8'h5a);
		@(posedge ref_clk);
		power_down_reset_n <= 1'b0;
		// One sample short of the minimum must not reset; the next one must.
		step(ARSC_RSTN_LOW_MIN_CYC - 1);
		chk(1'b0, device_in_reset);
		step(1);
		chk(1'b1, device_in_reset);
		wr(ARSC_ADDR_LO_MIX, 8'hff);
		@(posedge ref_clk);
		power_down_reset_n <= 1'b1;
		step(3);
		rd(ARSC_ADDR_LO_MIX, 8'h00);
		rd(ARSC_ADDR_HP_MIX, 8'h00);
	endtask : t_pin_reset

	task t_slave();
		@(posedge ref_clk);
		audio_format_sel <= 2'h1;
		sample_rate_sel <= 2'h2;
		step(2);
		chk(4'h9, active_format);
		@(posedge ref_clk);
		ref_voltage_power <= 1'b1;
		step(100);
		chk(1'b0, normal_op);
		chk(4'h4, startup_state);
		chk(2'h0, {frame_clock_oe, bit_clock_oe});
		@(posedge ref_clk);
		clk_en <= 1'b1;
		for (int n = 0; n < 400 && normal_op !== 1'b1; n++) begin
			@(posedge ref_clk);
		end
		#1;
		chk(1'b1, normal_op);
		if (normal_op !== 1'b1) begin
			summarize();
		end
		chk(3'h7, clocks_present);
	endtask : t_slave

	task t_dac();
		logic [15:0] vals [3];
		logic [15:0] codes [3];
		vals = '{ARSC_DAC_POS_FULL, ARSC_DAC_NEG_FULL, ARSC_DAC_MID};
		// Offset code seen by the converter: full negative at zero, midpoint at half scale.
		codes = '{16'hffff, 16'h0000, 16'h8000};
		foreach (vals[i]) begin
			@(posedge ref_clk);
			dac_valid <= 1'b1;
			dac_left <= vals[i];
			@(posedge ref_clk);
			dac_valid <= 1'b0;
			#1;
			chk(codes[i], dac_code_left);
		end
		wr(ARSC_ADDR_SRC_MODE, 8'h04);
		wr(ARSC_ADDR_LO_MIX, 8'h80);
		@(posedge ref_clk);
		adc_valid <= 1'b1;
		dac_valid <= 1'b1;
		adc_left <= 16'h0100;
		adc_right <= 16'h0300;
		dac_left <= 16'h0100;
		dac_right <= 16'h0300;
		@(posedge ref_clk);
		adc_valid <= 1'b0;
		dac_valid <= 1'b0;
		#1;
		chk(16'h0200, rec_left);
		chk(16'h0200, lo_dac_left);
		chk(1'b1, rec_valid);
		chk(16'h0200, rec_right);
		chk(1'b1, lo_dac_valid);
		chk(16'h0200, lo_dac_right);
		chk(16'h8200, dac_code_right);
	endtask : t_dac

	task t_master();
		@(posedge ref_clk);
		master_sel <= 1'b1;
		step(1);
		chk(2'h3, {frame_clock_oe, bit_clock_oe});
		// The bit clock starts high and falls after four system cycles of master mode.
		step(3);
		chk(1'b0, bit_clock_out);
		@(posedge ref_clk);
		master_sel <= 1'b0;
		step(1);
		chk(2'h0, {frame_clock_oe, bit_clock_oe});
	endtask : t_master

	initial begin
		rst = 1'b1;
		power_down_reset_n = 1'b0;
		{reg_we, reg_re, master_sel, ref_voltage_power, clk_en, adc_valid, dac_valid} = 7'h00;
		{reg_addr, reg_wdata, audio_format_sel, sample_rate_sel} = 20'h00000;
		{adc_left, adc_right, dac_left, dac_right} = 64'h0;
		fail_count = 0;
		check_count = 0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		// Reset pin held low through power-up, then released.
		step(20);
		@(posedge ref_clk);
		power_down_reset_n <= 1'b1;
		step(3);
		rd(ARSC_ADDR_SRC_MODE, 8'h00);
		rd(ARSC_ADDR_LO_MIX, 8'h00);
		rd(ARSC_ADDR_HP_MIX, 8'h00);
		rd(8'h24, 8'h00);
		t_src();
		t_mix();
		t_pin_reset();
		t_slave();
		t_dac();
		t_master();
		summarize();
	end
endmodule : testbench

bind analog_route_and_startup_ctrl arsc_assertions #(.SAMPLE_W(SAMPLE_W)) u_arsc_assertions (
	.ref_clk(ref_clk), .rst(rst), .power_down_reset_n(power_down_reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .master_sel(master_sel),
	.frame_clock_oe(frame_clock_oe), .bit_clock_oe(bit_clock_oe), .device_in_reset(device_in_reset),
	.normal_op(normal_op), .clocks_present(clocks_present), .line_out_diff_sel(line_out_diff_sel),
	.line_out_stereo_en(line_out_stereo_en), .lo_dac_mono_mix(lo_dac_mono_mix), .dac_valid(dac_valid),
	.dac_left(dac_left), .dac_code_left(dac_code_left));
